//--- pbfs_pkg.sv
// Package for the port B output-enable and function-select block
package pbfs_pkg;

   // ==========================================================
   // Register map (byte addresses inside the port window)
   localparam logic [11:0] PBFS_OFS_OUTPUT_ENABLE = 12'h004;
   localparam logic [11:0] PBFS_OFS_BUS_SEL       = 12'h008;
   localparam logic [11:0] PBFS_OFS_SERIAL_SEL    = 12'h00C;
   localparam logic [11:0] PBFS_OFS_THIRD_SEL     = 12'h010;

   // ==========================================================
   // Field layout and reset values
   localparam int          PBFS_PINS       = 8;
   localparam int          PBFS_FIELD_LSB  = 0;
   localparam int          PBFS_FIELD_MSB  = 7;
   localparam logic [7:0]  PBFS_RESET_BITS = 8'h00;
   localparam logic [23:0] PBFS_UPPER_ZERO = 24'h000000;

   // Serial pin roles, bit index inside the serial select register
   localparam int PBFS_SER1_DATA_OUT  = 0;
   localparam int PBFS_SER1_DATA_IN   = 1;
   localparam int PBFS_SER1_CLOCK     = 2;
   localparam int PBFS_SER1_FRAME_SEL = 3;
   localparam int PBFS_SER2_DATA_OUT  = 4;
   localparam int PBFS_SER2_DATA_IN   = 5;
   localparam int PBFS_SER2_CLOCK     = 6;
   localparam int PBFS_SER2_FRAME_SEL = 7;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [7:0] out;   // Value the owner wants on each pin
      logic [7:0] oe;    // Owner drives the pin when high
   } pbfs_drive_type;

   typedef struct packed {
      logic [7:0] pin_output_enable_bits;
      logic [7:0] bus_sel;
      logic [7:0] serial_sel;
      logic [7:0] third_sel;
   } pbfs_regs_type;

   // Whole state of the top module
   typedef struct packed {
      pbfs_regs_type  regs;
      pbfs_drive_type pins;
      logic [31:0]    prdata;
      logic           pready;
      logic           pslverr;
   } pbfs_state_type;

endpackage

//--- pbfs_pin_mux.sv
// Per-pin owner selection for the port B pins
`timescale 1ns/1ps
module pbfs_pin_mux
   import pbfs_pkg::*;
(
   // Selection registers
   input  wire pbfs_regs_type  regs,
   // Candidate drivers
   input  wire logic [7:0]     port_data,
   input  wire pbfs_drive_type bus_drv,
   input  wire pbfs_drive_type ser_drv,
   input  wire pbfs_drive_type third_drv,
   // Chosen drive per pin
   output pbfs_drive_type      pin_drv
);

   genvar n;

   // ==========================================================
   // One selector per pin; fixed priority keeps a double select harmless
   generate
      for (n = 0; n < PBFS_PINS; n++) begin : g_pin
         always_comb begin
            if (regs.bus_sel[n]) begin
               pin_drv.out[n] = bus_drv.out[n];
               pin_drv.oe[n]  = bus_drv.oe[n];
            end else if (regs.serial_sel[n]) begin
               pin_drv.out[n] = ser_drv.out[n];
               pin_drv.oe[n]  = ser_drv.oe[n];
            end else if (regs.third_sel[n]) begin
               pin_drv.out[n] = third_drv.out[n];
               pin_drv.oe[n]  = third_drv.oe[n];
            end else begin
               // General-purpose bit: data and output-enable registers rule
               pin_drv.out[n] = port_data[n];
               pin_drv.oe[n]  = regs.pin_output_enable_bits[n];
            end
         end
      end
   endgenerate

endmodule

//--- pbfs_port_b.sv
// Port B output-enable and function-select block with APB register access
// ==========================================================
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module pbfs_port_b
   import pbfs_pkg::*;
(
   // Clock and reset
   input  wire logic           pclk,
   input  wire logic           presetn,
   // APB slave
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [11:0]    paddr,
   input  wire logic [31:0]    pwdata,
   output logic [31:0]         prdata,
   output logic                pready,
   output logic                pslverr,
   // Port data from the data register block
   input  wire logic [7:0]     port_data,
   // Alternate function drivers
   input  wire pbfs_drive_type bus_drv,
   input  wire pbfs_drive_type ser_drv,
   input  wire pbfs_drive_type third_drv,
   // Pin drive
   output logic [7:0]          pin_out,
   output logic [7:0]          pin_oe,
   // Select state for the peripherals that share the pins
   output logic [7:0]          bus_sel,
   output logic [7:0]          serial_sel,
   output logic [7:0]          third_sel
);

   pbfs_state_type state_q;
   pbfs_state_type state_d;
   pbfs_drive_type mux_drv;
   logic           setup_ph;
   logic           access_done;
   logic           hit_oe;
   logic           hit_bus;
   logic           hit_ser;
   logic           hit_third;
   logic           hit_any;

   // ==========================================================
   // Pin owner selection
   pbfs_pin_mux u_mux (
      .regs      (state_q.regs),
      .port_data (port_data),
      .bus_drv   (bus_drv),
      .ser_drv   (ser_drv),
      .third_drv (third_drv),
      .pin_drv   (mux_drv)
   );

   // ==========================================================
   // Address decode and APB phase flags
   always_comb begin
      hit_oe    = 1'b0;
      hit_bus   = 1'b0;
      hit_ser   = 1'b0;
      hit_third = 1'b0;
      if (paddr == PBFS_OFS_OUTPUT_ENABLE) begin
         hit_oe = 1'b1;
      end else if (paddr == PBFS_OFS_BUS_SEL) begin
         hit_bus = 1'b1;
      end else if (paddr == PBFS_OFS_SERIAL_SEL) begin
         hit_ser = 1'b1;
      end else if (paddr == PBFS_OFS_THIRD_SEL) begin
         hit_third = 1'b1;
      end
   end

   assign hit_any     = hit_oe | hit_bus | hit_ser | hit_third;
   assign setup_ph    = psel & ~penable;
   // Write lands only on the edge the master sees pready
   assign access_done = psel & penable & state_q.pready;

   // ==========================================================
   // Next state: registers, read data, ready and pin drive
   always_comb begin
      state_d        = state_q;
      state_d.pready = 1'b0;
      state_d.pins   = mux_drv;

      // Answer one cycle after setup, so every access has one wait-free access phase
      if (setup_ph) begin
         state_d.pready  = 1'b1;
         state_d.pslverr = ~hit_any;
         state_d.prdata  = 32'h00000000;
         if (!pwrite) begin
            // Upper bits always read as zero
            if (hit_oe) begin
               state_d.prdata = {PBFS_UPPER_ZERO, state_q.regs.pin_output_enable_bits};
            end else if (hit_bus) begin
               state_d.prdata = {PBFS_UPPER_ZERO, state_q.regs.bus_sel};
            end else if (hit_ser) begin
               state_d.prdata = {PBFS_UPPER_ZERO, state_q.regs.serial_sel};
            end else if (hit_third) begin
               state_d.prdata = {PBFS_UPPER_ZERO, state_q.regs.third_sel};
            end
         end
      end

      // Writes keep only the low byte; upper bits are not stored
      if (access_done && pwrite) begin
         if (hit_oe) begin
            state_d.regs.pin_output_enable_bits = pwdata[PBFS_FIELD_MSB:PBFS_FIELD_LSB];
         end else if (hit_bus) begin
            state_d.regs.bus_sel = pwdata[PBFS_FIELD_MSB:PBFS_FIELD_LSB];
         end else if (hit_ser) begin
            state_d.regs.serial_sel = pwdata[PBFS_FIELD_MSB:PBFS_FIELD_LSB];
         end else if (hit_third) begin
            state_d.regs.third_sel = pwdata[PBFS_FIELD_MSB:PBFS_FIELD_LSB];
         end
      end
   end

   // ==========================================================
   // State register; reset leaves every pin a port bit, undriven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q.regs.pin_output_enable_bits <= PBFS_RESET_BITS;
         state_q.regs.bus_sel                <= PBFS_RESET_BITS;
         state_q.regs.serial_sel             <= PBFS_RESET_BITS;
         state_q.regs.third_sel              <= PBFS_RESET_BITS;
         state_q.pins.out                    <= PBFS_RESET_BITS;
         state_q.pins.oe                     <= PBFS_RESET_BITS;
         state_q.prdata                      <= 32'h00000000;
         state_q.pready                      <= 1'b0;
         state_q.pslverr                     <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign prdata     = state_q.prdata;
   assign pready     = state_q.pready;
   assign pslverr    = state_q.pslverr;
   assign pin_out    = state_q.pins.out;
   assign pin_oe     = state_q.pins.oe;
   assign bus_sel    = state_q.regs.bus_sel;
   assign serial_sel = state_q.regs.serial_sel;
   assign third_sel  = state_q.regs.third_sel;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Written enable byte appears in the register after the access edge
   property p_oe_write;
      (access_done && pwrite && hit_oe)
         |=> (state_q.regs.pin_output_enable_bits == $past(pwdata[7:0]));
   endproperty
   a_oe_write: assert property (p_oe_write) else $error("enable write lost");

   // Read answers carry zero in the upper bits
   property p_upper_zero;
      (pready && !pwrite) |-> (prdata[31:8] == 24'h000000);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

   // Bus select hands the pin to the bus driver one cycle later
   property p_bus_route;
      state_q.regs.bus_sel[0]
         |=> (pin_out[0] == $past(bus_drv.out[0])) && (pin_oe[0] == $past(bus_drv.oe[0]));
   endproperty
   a_bus_route: assert property (p_bus_route) else $error("bus route wrong");

   // Serial select hands pin 4's enable to the serial driver when the bus is off
   property p_ser_route;
      (!state_q.regs.bus_sel[4] && state_q.regs.serial_sel[4]) |=> (pin_oe[4] == $past(ser_drv.oe[4]));
   endproperty
   a_ser_route: assert property (p_ser_route) else $error("serial route wrong");

   // Port mode follows the data and enable registers
   property p_port_mode;
      // Sampled reset keeps the release edge out: the pins still hold reset values then
      (presetn && state_q.regs.bus_sel == 8'h00 && state_q.regs.serial_sel == 8'h00
         && state_q.regs.third_sel == 8'h00)
         |=> (pin_out == $past(port_data))
             && (pin_oe == $past(state_q.regs.pin_output_enable_bits));
   endproperty
   a_port_mode: assert property (p_port_mode) else $error("port drive wrong");

   // Port bits with enable off never drive
   property p_idle_quiet;
      (state_q.regs == '0) |=> (pin_oe == 8'h00);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("pin driven while off");

   // Ready is a single-cycle answer to a setup phase
   property p_ready_pulse;
      setup_ph |=> pready ##1 (!pready || $past(setup_ph));
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready timing wrong");

   // Unmapped addresses report an error and store nothing
   property p_unmapped;
      (setup_ph && !hit_any) |=> pslverr ##1 $stable(state_q.regs);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

   // Bus select write lands in the register that routes the pins
   property p_bus_write;
      (access_done && pwrite && hit_bus)
         |=> (state_q.regs.bus_sel == $past(pwdata[7:0]));
   endproperty
   a_bus_write: assert property (p_bus_write) else $error("bus select write lost");

   // Serial select write lands likewise
   property p_ser_write;
      (access_done && pwrite && hit_ser)
         |=> (state_q.regs.serial_sel == $past(pwdata[7:0]));
   endproperty
   a_ser_write: assert property (p_ser_write) else $error("serial select write lost");

   // Third select has no field meaning here but must still store its low byte
   property p_third_write;
      (access_done && pwrite && hit_third)
         |=> (state_q.regs.third_sel == $past(pwdata[7:0]));
   endproperty
   a_third_write: assert property (p_third_write) else $error("third select write lost");

   // A read returns the enable byte as it stood at the setup edge
   property p_oe_read;
      (setup_ph && !pwrite && hit_oe)
         |=> (prdata == {24'h000000, $past(state_q.regs.pin_output_enable_bits)});
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("enable read wrong");

   // Mapped places answer without error
   property p_mapped_ok;
      (setup_ph && hit_any) |=> !pslverr;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");

   // Ready never comes without a setup phase just before it
   property p_ready_cause;
      pready |-> $past(setup_ph);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");

   // Reads leave every register untouched
   property p_read_quiet;
      (access_done && !pwrite) |=> $stable(state_q.regs);
   endproperty
   a_read_quiet: assert property (p_read_quiet) else $error("read changed a register");

   // ==========================================================
   // Per-pin routing checks; every pin, not just one sample bit
   genvar k;
   generate
      for (k = 0; k < PBFS_PINS; k++) begin : g_route_chk
         // Bus select owns value and enable whatever else is set
         property p_pin_bus;
            @(posedge pclk) disable iff (!presetn)
            state_q.regs.bus_sel[k]
               |=> (pin_out[k] == $past(bus_drv.out[k]))
                   && (pin_oe[k] == $past(bus_drv.oe[k]));
         endproperty
         a_pin_bus: assert property (p_pin_bus) else $error("bus pin route wrong");

         // Serial select owns the pin when the bus does not
         property p_pin_ser;
            @(posedge pclk) disable iff (!presetn)
            (!state_q.regs.bus_sel[k] && state_q.regs.serial_sel[k])
               |=> (pin_out[k] == $past(ser_drv.out[k]))
                   && (pin_oe[k] == $past(ser_drv.oe[k]));
         endproperty
         a_pin_ser: assert property (p_pin_ser) else $error("serial pin route wrong");

         // Third select only when both others are clear
         property p_pin_third;
            @(posedge pclk) disable iff (!presetn)
            (!state_q.regs.bus_sel[k] && !state_q.regs.serial_sel[k]
               && state_q.regs.third_sel[k])
               |=> (pin_out[k] == $past(third_drv.out[k]))
                   && (pin_oe[k] == $past(third_drv.oe[k]));
         endproperty
         a_pin_third: assert property (p_pin_third) else $error("third pin route wrong");
      end
   endgenerate

   property p_cov_write;
      access_done && pwrite && hit_ser;
   endproperty
   c_cov_write: cover property (p_cov_write);

   property p_cov_read;
      access_done && !pwrite && hit_oe;
   endproperty
   c_cov_read: cover property (p_cov_read);

   property p_cov_bus_pin;
      state_q.regs.bus_sel != 8'h00 ##1 pin_oe != 8'h00;
   endproperty
   c_cov_bus_pin: cover property (p_cov_bus_pin);

   property p_cov_unmapped;
      setup_ph && !hit_any;
   endproperty
   c_cov_unmapped: cover property (p_cov_unmapped);

   property p_cov_third_pin;
      state_q.regs.third_sel != 8'h00 ##1 pin_oe != 8'h00;
   endproperty
   c_cov_third_pin: cover property (p_cov_third_pin);

endmodule

//--- pbfs_far_model.sv
// Model of the external bus, serial and third-function peripherals sharing the port B pins
`timescale 1ns/1ps
module pbfs_far_model
   import pbfs_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Alternate function drivers
   output pbfs_drive_type bus_drv,
   output pbfs_drive_type ser_drv,
   output pbfs_drive_type third_drv
);
   // ==========================================================
   // Peripherals stay quiet in reset, then drive fixed patterns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_drv   <= '0;
         ser_drv   <= '0;
         third_drv <= '0;
      end else begin
         bus_drv   <= '{out: 8'hA5, oe: 8'hFF};
         // Data-in roles never drive, so their pins must not be driven
         ser_drv   <= '{out: 8'h3C, oe: 8'hDD};
         third_drv <= '{out: 8'h96, oe: 8'hF0};
      end
   end
endmodule

//--- pbfs_port_b_test.sv
// Self-checking testbench for the port B function-select block
`timescale 1ns/1ps
module pbfs_port_b_test;
   import pbfs_pkg::*;
   logic           pclk, presetn, psel, penable, pwrite;
   logic [11:0]    paddr;
   logic [31:0]    pwdata, prdata, rd;
   logic           pready, pslverr, err;
   logic [7:0]     port_data, pin_out, pin_oe, bus_sel, serial_sel, third_sel, en;
   pbfs_drive_type bus_drv, ser_drv, third_drv;
   int             num_errors, comparisons;

   pbfs_far_model pbfs_far_model_inst (.pclk(pclk), .presetn(presetn), .bus_drv(bus_drv),
      .ser_drv(ser_drv), .third_drv(third_drv));
   pbfs_port_b pbfs_port_b_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_data(port_data), .bus_drv(bus_drv),
      .ser_drv(ser_drv), .third_drv(third_drv), .pin_out(pin_out), .pin_oe(pin_oe),
      .bus_sel(bus_sel), .serial_sel(serial_sel), .third_sel(third_sel));

   // ==========================================================
   // Shared tasks
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // One APB transfer; an idle edge first keeps drives one per time step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0, "no ready");
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Pins settle one cycle after a register write
   task automatic chkpins(input logic [7:0] sel, input pbfs_drive_type d);
      repeat (3) @(posedge pclk);
      #1;
      chk({24'h0, pin_out}, {24'h0, (d.out & sel) | (port_data & ~sel)}, "pin value");
      chk({24'h0, pin_oe}, {24'h0, (d.oe & sel) | (en & ~sel)}, "pin enable");
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, "read data");
      chk({31'h0, err}, 32'h0, "error flag");
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rdchk(PBFS_OFS_OUTPUT_ENABLE, 32'h0);
      rdchk(PBFS_OFS_BUS_SEL, 32'h0);
      rdchk(PBFS_OFS_SERIAL_SEL, 32'h0);
      rdchk(PBFS_OFS_THIRD_SEL, 32'h0);
      chk({pin_oe, bus_sel, serial_sel, third_sel}, 32'h0, "reset pins");
      $display("test reset done");
   endtask

   task automatic t_enable;
      en = 8'h5A;
      // Asymmetric data pattern so a swapped pin order shows up
      port_data <= 8'h4B;
      apb(1'b1, PBFS_OFS_OUTPUT_ENABLE, 32'hFFFF_FF5A);
      rdchk(PBFS_OFS_OUTPUT_ENABLE, 32'h0000_005A);
      chkpins(8'h00, bus_drv);
      $display("test enable done");
   endtask

   task automatic t_bus;
      apb(1'b1, PBFS_OFS_BUS_SEL, 32'h1234_560F);
      // Select outputs change at the write edge itself, so look once the pins settle
      chkpins(8'h0F, bus_drv);
      chk({24'h0, bus_sel}, 32'h0F, "bus select");
      apb(1'b1, PBFS_OFS_BUS_SEL, 32'h0);
      $display("test bus done");
   endtask

   task automatic t_serial;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, PBFS_OFS_SERIAL_SEL, 32'h1 << i);
         chkpins(8'h01 << i, ser_drv);
         chk({24'h0, serial_sel}, 32'h1 << i, "serial select");
      end
      apb(1'b1, PBFS_OFS_SERIAL_SEL, 32'h0);
      $display("test serial done");
   endtask

   task automatic t_third;
      apb(1'b1, PBFS_OFS_THIRD_SEL, 32'hFFFF_FFFF);
      rdchk(PBFS_OFS_THIRD_SEL, 32'h0000_00FF);
      chkpins(8'hFF, third_drv);
      chk({24'h0, third_sel}, 32'hFF, "third select");
      apb(1'b1, PBFS_OFS_THIRD_SEL, 32'h0);
      chkpins(8'h00, third_drv);
      chk({24'h0, third_sel}, 32'h00, "third select");
      $display("test third done");
   endtask

   // Unmapped place is refused and leaves the output-enable register alone
   task automatic t_unmapped;
      apb(1'b1, 12'h014, 32'h0000_00FF);
      chk({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, 32'h0, "unmapped data");
      chk({31'h0, err}, 32'h1, "unmapped error");
      rdchk(PBFS_OFS_OUTPUT_ENABLE, 32'h0000_005A);
      $display("test unmapped done");
   endtask

   // Reset in mid-run must bring every written register and pin back to port mode
   task automatic t_rereset;
      apb(1'b1, PBFS_OFS_BUS_SEL, 32'h0000_00F0);
      apb(1'b1, PBFS_OFS_SERIAL_SEL, 32'h0000_0003);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk({pin_oe, bus_sel, serial_sel, third_sel}, 32'h0, "rereset pins");
      chk({24'h0, pin_out}, 32'h0, "rereset value");
      rdchk(PBFS_OFS_OUTPUT_ENABLE, 32'h0);
      rdchk(PBFS_OFS_BUS_SEL, 32'h0);
      rdchk(PBFS_OFS_SERIAL_SEL, 32'h0);
      en = 8'h00;
      chkpins(8'h00, bus_drv);
      $display("test rereset done");
   endtask

   // ==========================================================
   // Clock, reset, sequence and watchdog
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      port_data = 8'hC3;
      en = 8'h00;
      num_errors = 0;
      comparisons = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_enable();
      t_bus();
      t_serial();
      t_third();
      t_unmapped();
      t_rereset();
      complete_run();
   end

   initial begin
      repeat (2000) @(posedge pclk);
      num_errors++;
      complete_run();
   end
endmodule
